// ==== port_cde_mux_pkg.sv ====
package port_cde_mux_pkg;

    // ****************************************************************
    // Pin positions within each port
    // ****************************************************************
    localparam int PC_T3A_BIT   = 6;
    localparam int PC_T4A_BIT   = 7;
    localparam int PD_T4D_BIT   = 7;
    localparam int PD_T4DN_BIT  = 6;
    localparam int PD_XCK_BIT   = 5;
    localparam int PD_ICP_BIT   = 4;
    localparam int PD_TX_BIT    = 3;
    localparam int PD_RX_BIT    = 2;
    localparam int PD_SDA_BIT   = 1;
    localparam int PD_SCL_BIT   = 0;
    localparam int PE_IRQ6_BIT  = 6;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 40;
    localparam int SPIKE_REJECT_NS = 50;
    // A pulse under the reject time can span this many samples, so the filter waits one more.
    localparam int SPIKE_CYCLES =
        (SPIKE_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPIKE_CNT_W  = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic       FILT_RESET = 1'h1;

endpackage

// ==== spike_filter.sv ====
module spike_filter (
    input  wire logic clk,
    input  wire logic rstSync,
    input  wire logic enable,
    input  wire logic din,
    output logic      dout
);

    // ****************************************************************
    // Glitch rejection
    // ****************************************************************
    // The output moves only after the input has differed from it on
    // SPIKE_CYCLES + 1 samples in a row, so shorter pulses never pass.
    logic [port_cde_mux_pkg::SPIKE_CNT_W-1:0] cnt_r;
    logic                                     differs;
    logic                                     settled;

    assign differs = enable && (din != dout);
    assign settled = (cnt_r == port_cde_mux_pkg::SPIKE_CNT_W'(port_cde_mux_pkg::SPIKE_CYCLES));

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            cnt_r <= '0;
            dout  <= port_cde_mux_pkg::FILT_RESET;
        end else if (!enable) begin
            cnt_r <= '0;
            dout  <= din;
        end else if (!differs) begin
            cnt_r <= '0;
        end else if (settled) begin
            cnt_r <= '0;
            dout  <= din;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    a_filter_hold: assert property (@(posedge clk) disable iff (!rstSync)
        enable && $past(enable) && dout != $past(dout) |-> $past(din, 1) == dout
        && $past(din, 2) == dout && $past(din, 3) == dout)
        else $error("filter passed a short spike");

endmodule

// ==== port_cde_alt_function_mux.sv ====
// Functional notes
// - PC6 carries timer3 compare A when enabled.
// - PC6 carries inverted timer4 A if output.
// - PD7 carries timer4 D if output.
// - PD6 carries inverted timer4 D if output.
// - PD7/PD6 feed timer0/timer1 external clocks.
// - PD5 USART sync clock, direction selects output.
// - PD5 also feeds UART clear-to-send input.
// - PD4 feeds timer1 input capture.
// - Transmitter enabled forces PD3 output, no pull-up.
// - Receiver enabled forces PD2 input, latch pull-up.
// - Two-wire enable makes PD1 open-drain SDA.
// - Two-wire enable makes PD0 open-drain SCL.
// - Two-wire inputs spike-filtered below 50ns.
// - PD0 carries timer0 compare B otherwise.
// - PD0..3 feed interrupts, input kept enabled.
// - PE6 feeds interrupt six and comparator.
module port_cde_alt_function_mux (
    input  wire logic       clk,
    input  wire logic       nrst,
    // Port registers.
    input  wire logic [7:0] portcDirection,
    input  wire logic [7:0] portcOutputLatch,
    input  wire logic [7:0] portdDirection,
    input  wire logic [7:0] portdOutputLatch,
    input  wire logic [7:0] porteDirection,
    input  wire logic [7:0] porteOutputLatch,
    input  wire logic       globalPullupDisable,
    input  wire logic       sleepInputGate,
    // Peripheral controls and outputs.
    input  wire logic       timer3CmpAEnable,
    input  wire logic       timer3CmpAOut,
    input  wire logic       timer4CmpAEnable,
    input  wire logic       timer4CmpAOut,
    input  wire logic       timer4CmpDEnable,
    input  wire logic       timer4CmpDOut,
    input  wire logic       timer0CmpBEnable,
    input  wire logic       timer0CmpBOut,
    input  wire logic       usartSyncMode,
    input  wire logic       usartSyncClockOut,
    input  wire logic       usartTransmitterEnable,
    input  wire logic       usartTransmitData,
    input  wire logic       usartReceiverEnable,
    input  wire logic       twoWireEnable,
    input  wire logic       sdaOut,
    input  wire logic       sclOut,
    input  wire logic [3:0] extIrqEnableLow,
    input  wire logic       extIrqSixEnable,
    // Pins.
    input  wire logic [7:0] portcPinIn,
    output logic      [7:0] portcPinOut,
    output logic      [7:0] portcPinOe,
    output logic      [7:0] portcPullup,
    input  wire logic [7:0] portdPinIn,
    output logic      [7:0] portdPinOut,
    output logic      [7:0] portdPinOe,
    output logic      [7:0] portdPullup,
    output logic      [7:0] portdSlewLimit,
    input  wire logic [7:0] portePinIn,
    output logic      [7:0] portePinOut,
    output logic      [7:0] portePinOe,
    output logic      [7:0] portePullup,
    // Inputs seen by peripherals.
    output logic [7:0]      portcPinValue,
    output logic [7:0]      portdPinValue,
    output logic [7:0]      portePinValue,
    output logic            timer0ExtClockIn,
    output logic            timer1ExtClockIn,
    output logic            timer1CaptureInput,
    output logic            timer3CaptureInput,
    output logic            usartSyncClockIn,
    output logic            usartClearToSend,
    output logic            usartReceiveData,
    output logic            sdaIn,
    output logic            sclIn,
    output logic [3:0]      extIrqLowInput,
    output logic            extIrqSixInput,
    output logic            comparatorPinInput
);

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    logic rstMeta_r;
    logic rstSync;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_r <= 1'b0;
            rstSync   <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync   <= rstMeta_r;
        end
    end

    // ****************************************************************
    // Override signals per pin
    // ****************************************************************
    // Each port bit has pull-up, direction, value and input-enable
    // override pairs; a zero enable leaves the port register in charge.
    logic [7:0] cPuoe;
    logic [7:0] cPuov;
    logic [7:0] cDdoe;
    logic [7:0] cDdov;
    logic [7:0] cPvoe;
    logic [7:0] cPvov;
    logic [7:0] cDieoe;
    logic [7:0] cDieov;
    logic [7:0] dPuoe;
    logic [7:0] dPuov;
    logic [7:0] dDdoe;
    logic [7:0] dDdov;
    logic [7:0] dPvoe;
    logic [7:0] dPvov;
    logic [7:0] dDieoe;
    logic [7:0] dDieov;
    logic [7:0] ePuoe;
    logic [7:0] ePuov;
    logic [7:0] eDdoe;
    logic [7:0] eDdov;
    logic [7:0] ePvoe;
    logic [7:0] ePvov;
    logic [7:0] eDieoe;
    logic [7:0] eDieov;

    wire xckDrive = usartSyncMode && portdDirection[port_cde_mux_pkg::PD_XCK_BIT];
    wire t4aShown = timer4CmpAEnable && portcDirection[port_cde_mux_pkg::PC_T3A_BIT];
    wire t4dShown = timer4CmpDEnable && portdDirection[port_cde_mux_pkg::PD_T4D_BIT];
    wire t4dnShown = timer4CmpDEnable && portdDirection[port_cde_mux_pkg::PD_T4DN_BIT];
    wire t4aTrue = timer4CmpAEnable && portcDirection[port_cde_mux_pkg::PC_T4A_BIT];
    wire t0bShown = timer0CmpBEnable && !twoWireEnable;

    always_comb begin
        {cPuoe, cPuov, cDdoe, cDdov, cPvoe, cPvov, cDieoe, cDieov} = '0;
        {dPuoe, dPuov, dDdoe, dDdov, dPvoe, dPvov, dDieoe, dDieov} = '0;
        {ePuoe, ePuov, eDdoe, eDdov, ePvoe, ePvov, eDieoe, eDieov} = '0;
        // Timer3 compare A takes priority over the complementary timer4 A.
        cPvoe[6] = timer3CmpAEnable || t4aShown;
        cPvov[6] = timer3CmpAEnable ? timer3CmpAOut : !timer4CmpAOut;
        cPvoe[7] = t4aTrue;
        cPvov[7] = timer4CmpAOut;
        dPvoe[7] = t4dShown;
        dPvov[7] = timer4CmpDOut;
        dPvoe[6] = t4dnShown;
        dPvov[6] = !timer4CmpDOut;
        dDdoe[5] = xckDrive;
        dDdov[5] = 1'b1;
        dPvoe[5] = xckDrive;
        dPvov[5] = usartSyncClockOut;
        dPuoe[3] = usartTransmitterEnable;
        dDdoe[3] = usartTransmitterEnable;
        dDdov[3] = 1'b1;
        dPvoe[3] = usartTransmitterEnable;
        dPvov[3] = usartTransmitData;
        dPuoe[2] = usartReceiverEnable;
        dPuov[2] = portdOutputLatch[2] && !globalPullupDisable;
        dDdoe[2] = usartReceiverEnable;
        // Open drain: the pin is only ever driven low, direction carries data.
        dPuoe[1:0] = {2{twoWireEnable}};
        dPuov[1:0] = portdOutputLatch[1:0] & {2{!globalPullupDisable}};
        dDdoe[1:0] = {2{twoWireEnable}};
        dDdov[1]   = !sdaOut;
        dDdov[0]   = !sclOut;
        dPvoe[1]   = twoWireEnable;
        dPvoe[0]   = twoWireEnable || t0bShown;
        dPvov[0]   = twoWireEnable ? 1'b0 : timer0CmpBOut;
        dDieoe[3:0] = extIrqEnableLow;
        dDieov[3:0] = 4'hF;
        eDieoe[6]  = extIrqSixEnable;
        eDieov[6]  = 1'b1;
    end

    // ****************************************************************
    // Pin drivers, one generate loop over bits
    // ****************************************************************
    logic [7:0] cDir;
    logic [7:0] dDir;
    logic [7:0] eDir;
    logic [7:0] cIn;
    logic [7:0] dIn;
    logic [7:0] eIn;
    logic [7:0] cMeta_r;
    logic [7:0] dMeta_r;
    logic [7:0] eMeta_r;
    logic [7:0] cSync_r;
    logic [7:0] dSync_r;
    logic [7:0] eSync_r;

    for (genvar i = 0; i < 8; i++) begin : g_bit
        assign cDir[i] = cDdoe[i] ? cDdov[i] : portcDirection[i];
        assign dDir[i] = dDdoe[i] ? dDdov[i] : portdDirection[i];
        assign eDir[i] = eDdoe[i] ? eDdov[i] : porteDirection[i];
        assign portcPinOe[i]  = cDir[i];
        assign portdPinOe[i]  = dDir[i];
        assign portePinOe[i]  = eDir[i];
        assign portcPinOut[i] = cPvoe[i] ? cPvov[i] : portcOutputLatch[i];
        assign portdPinOut[i] = dPvoe[i] ? dPvov[i] : portdOutputLatch[i];
        assign portePinOut[i] = ePvoe[i] ? ePvov[i] : porteOutputLatch[i];
        assign portcPullup[i] = cPuoe[i] ? cPuov[i] :
            (!cDir[i] && portcOutputLatch[i] && !globalPullupDisable);
        assign portdPullup[i] = dPuoe[i] ? dPuov[i] :
            (!dDir[i] && portdOutputLatch[i] && !globalPullupDisable);
        assign portePullup[i] = ePuoe[i] ? ePuov[i] :
            (!eDir[i] && porteOutputLatch[i] && !globalPullupDisable);
        // Input path is gated in sleep unless an override keeps it alive.
        assign cIn[i] = (cDieoe[i] ? cDieov[i] : !sleepInputGate) && cSync_r[i];
        assign dIn[i] = (dDieoe[i] ? dDieov[i] : !sleepInputGate) && dSync_r[i];
        assign eIn[i] = (eDieoe[i] ? eDieov[i] : !sleepInputGate) && eSync_r[i];
    end

    assign portdSlewLimit = {6'h00, {2{twoWireEnable}}};

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            cMeta_r <= port_cde_mux_pkg::PORT_RESET;
            dMeta_r <= port_cde_mux_pkg::PORT_RESET;
            eMeta_r <= port_cde_mux_pkg::PORT_RESET;
            cSync_r <= port_cde_mux_pkg::PORT_RESET;
            dSync_r <= port_cde_mux_pkg::PORT_RESET;
            eSync_r <= port_cde_mux_pkg::PORT_RESET;
        end else begin
            cMeta_r <= portcPinIn;
            dMeta_r <= portdPinIn;
            eMeta_r <= portePinIn;
            cSync_r <= cMeta_r;
            dSync_r <= dMeta_r;
            eSync_r <= eMeta_r;
        end
    end

    // ****************************************************************
    // Peripheral input routing
    // ****************************************************************
    logic sdaFilt;
    logic sclFilt;

    spike_filter u_sdaFilter (
        .clk     (clk),
        .rstSync (rstSync),
        .enable  (twoWireEnable),
        .din     (dSync_r[port_cde_mux_pkg::PD_SDA_BIT]),
        .dout    (sdaFilt)
    );

    spike_filter u_sclFilter (
        .clk     (clk),
        .rstSync (rstSync),
        .enable  (twoWireEnable),
        .din     (dSync_r[port_cde_mux_pkg::PD_SCL_BIT]),
        .dout    (sclFilt)
    );

    assign portcPinValue      = cIn;
    assign portdPinValue      = dIn;
    assign portePinValue      = eIn;
    assign timer0ExtClockIn   = dIn[port_cde_mux_pkg::PD_T4D_BIT];
    assign timer1ExtClockIn   = dIn[port_cde_mux_pkg::PD_T4DN_BIT];
    assign timer1CaptureInput = dIn[port_cde_mux_pkg::PD_ICP_BIT];
    assign timer3CaptureInput = cIn[port_cde_mux_pkg::PC_T4A_BIT];
    assign usartSyncClockIn   = usartSyncMode && !xckDrive && dIn[5];
    assign usartClearToSend   = dIn[port_cde_mux_pkg::PD_XCK_BIT];
    assign usartReceiveData   = dIn[port_cde_mux_pkg::PD_RX_BIT];
    assign sdaIn              = sdaFilt;
    assign sclIn              = sclFilt;
    assign extIrqLowInput     = dIn[3:0];
    assign extIrqSixInput     = eIn[port_cde_mux_pkg::PE_IRQ6_BIT];
    // Analog path bypasses the input gate, here modelled by the synced level.
    assign comparatorPinInput = eSync_r[port_cde_mux_pkg::PE_IRQ6_BIT];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync);

    a_t3a_drive: assert property (timer3CmpAEnable |-> portcPinOut[6] == timer3CmpAOut)
        else $error("PC6 not timer3 A");
    a_t4a_comp: assert property (!timer3CmpAEnable && t4aShown
        |-> portcPinOut[6] == !timer4CmpAOut) else $error("PC6 not inverted timer4 A");
    a_t4d_pair: assert property (t4dShown && t4dnShown
        |-> portdPinOut[7] != portdPinOut[6]) else $error("PD7/PD6 not complementary");
    a_tx_force: assert property (usartTransmitterEnable |-> portdPinOe[3] && !portdPullup[3]
        && portdPinOut[3] == usartTransmitData) else $error("PD3 not transmitting");
    a_rx_input: assert property (usartReceiverEnable |-> !portdPinOe[2])
        else $error("PD2 not input");
    a_twi_opendrain: assert property (twoWireEnable
        |-> !portdPinOut[1] && !portdPinOut[0] && portdPinOe[1] == !sdaOut)
        else $error("two-wire not open drain");
    a_timer0_cmp_b_out_blocked: assert property (twoWireEnable |-> portdPinOut[0] == 1'b0)
        else $error("timer0 B leaked onto SCL");
    a_t0b_drive: assert property (timer0CmpBEnable && !twoWireEnable
        |-> portdPinOut[0] == timer0CmpBOut)
        else $error("PD0 not timer0 B");
    a_xck_drive: assert property (usartSyncMode && portdDirection[5]
        |-> portdPinOe[5] && portdPinOut[5] == usartSyncClockOut)
        else $error("PD5 not driving the clock");
    a_irq_path: assert property (extIrqEnableLow[0] && $past(dMeta_r[0])
        |-> extIrqLowInput[0]) else $error("interrupt input path gated");
    // PD3 has no direction or value override other than the transmitter, so it must follow the registers.
    a_plain_port: assert property (!usartTransmitterEnable
        |-> portdPinOe[3] == portdDirection[3] && portdPinOut[3] == portdOutputLatch[3])
        else $error("PD3 not following port registers");

    c_tx_on:  cover property (usartTransmitterEnable && usartTransmitData);
    c_xck:    cover property (xckDrive && usartSyncClockOut);
    c_twi_on: cover property (twoWireEnable && !sdaOut);
    c_t4d:    cover property (t4dShown && t4dnShown);
    c_irq6:   cover property (extIrqSixEnable && extIrqSixInput);

endmodule

// ==== pin_partner.sv ====
// ********************************************************************
// External circuitry on one eight-pin port
// ********************************************************************
module pin_partner (
    input  wire logic       clk,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullEn,
    input  wire logic [7:0] extEn,
    input  wire logic [7:0] extVal,
    output logic      [7:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] floatPattern_r = 8'h55;
    // A floating pin flips every cycle, so a missing drive never reads as a settled level.
    always @(posedge clk) begin
        floatPattern_r <= ~floatPattern_r;
    end
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extVal)
                    | (~pinOe & ~extEn & pullEn)
                    | (~pinOe & ~extEn & ~pullEn & floatPattern_r);
endmodule

// ==== port_cde_alt_function_mux_tb_top.sv ====
module port_cde_alt_function_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Stimulus and observed state
    // ****************************************************************
    logic clk = 1'h0, nrst = 1'h0;
    logic [7:0] portcDirection = 8'h00, portcOutputLatch = 8'h00, portdDirection = 8'h00;
    logic [7:0] portdOutputLatch = 8'h00, porteDirection = 8'h00, porteOutputLatch = 8'h00;
    logic globalPullupDisable = 1'h0, sleepInputGate = 1'h0, timer3CmpAEnable = 1'h0;
    logic timer3CmpAOut = 1'h0, timer4CmpAEnable = 1'h0, timer4CmpAOut = 1'h0;
    logic timer4CmpDEnable = 1'h0, timer4CmpDOut = 1'h0, timer0CmpBEnable = 1'h0;
    logic timer0CmpBOut = 1'h0, usartSyncMode = 1'h0, usartSyncClockOut = 1'h0;
    logic usartTransmitterEnable = 1'h0, usartTransmitData = 1'h0, usartReceiverEnable = 1'h0;
    logic twoWireEnable = 1'h0, sdaOut = 1'h1, sclOut = 1'h1, extIrqSixEnable = 1'h0;
    logic [3:0] extIrqEnableLow = 4'h0, extIrqLowInput;
    logic [7:0] cExtEn = 8'h00, cExtVal = 8'h00, dExtEn = 8'h00, dExtVal = 8'h00;
    logic [7:0] eExtEn = 8'h00, eExtVal = 8'h00, portcPinIn, portdPinIn, portePinIn;
    logic [7:0] portcPinOut, portcPinOe, portcPullup, portdPinOut, portdPinOe, portdPullup;
    logic [7:0] portdSlewLimit, portePinOut, portePinOe, portePullup;
    logic [7:0] portcPinValue, portdPinValue, portePinValue;
    logic timer0ExtClockIn, timer1ExtClockIn, timer1CaptureInput, timer3CaptureInput;
    logic usartSyncClockIn, usartClearToSend, usartReceiveData, sdaIn, sclIn;
    logic extIrqSixInput, comparatorPinInput;
    int failures = 0;
    int compares = 0;
    port_cde_alt_function_mux i_dut (.clk, .nrst, .portcDirection, .portcOutputLatch,
        .portdDirection, .portdOutputLatch, .porteDirection, .porteOutputLatch,
        .globalPullupDisable, .sleepInputGate, .timer3CmpAEnable, .timer3CmpAOut,
        .timer4CmpAEnable, .timer4CmpAOut, .timer4CmpDEnable, .timer4CmpDOut,
        .timer0CmpBEnable, .timer0CmpBOut, .usartSyncMode, .usartSyncClockOut,
        .usartTransmitterEnable, .usartTransmitData, .usartReceiverEnable, .twoWireEnable,
        .sdaOut, .sclOut, .extIrqEnableLow, .extIrqSixEnable, .portcPinIn, .portcPinOut,
        .portcPinOe, .portcPullup, .portdPinIn, .portdPinOut, .portdPinOe, .portdPullup,
        .portdSlewLimit, .portePinIn, .portePinOut, .portePinOe, .portePullup,
        .portcPinValue, .portdPinValue, .portePinValue, .timer0ExtClockIn, .timer1ExtClockIn,
        .timer1CaptureInput, .timer3CaptureInput, .usartSyncClockIn, .usartClearToSend,
        .usartReceiveData, .sdaIn, .sclIn, .extIrqLowInput, .extIrqSixInput,
        .comparatorPinInput);
    pin_partner i_pc (.clk, .pinOut(portcPinOut), .pinOe(portcPinOe), .pullEn(portcPullup),
        .extEn(cExtEn), .extVal(cExtVal), .pinLevel(portcPinIn));
    pin_partner i_pd (.clk, .pinOut(portdPinOut), .pinOe(portdPinOe), .pullEn(portdPullup),
        .extEn(dExtEn), .extVal(dExtVal), .pinLevel(portdPinIn));
    pin_partner i_pe (.clk, .pinOut(portePinOut), .pinOe(portePinOe), .pullEn(portePullup),
        .extEn(eExtEn), .extVal(eExtVal), .pinLevel(portePinIn));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_portc;
        @(posedge clk);
        portcDirection <= 8'hC0;
        portcOutputLatch <= 8'h40;
        {timer3CmpAEnable, timer3CmpAOut, timer4CmpAEnable, timer4CmpAOut} <= 4'hA;
        wt(1);
        chk(portcPinOut[7:6], 2'h0);
        chk(portcPinOe[7:6], 2'h3);
        timer3CmpAEnable <= 1'h0;
        portcOutputLatch <= 8'h00;
        wt(1);
        chk(portcPinOut[6], 1'h1);
        {timer4CmpAEnable, timer4CmpAOut, portcOutputLatch, portcDirection} <= {2'h1, 16'h4000};
        wt(1);
        chk(portcPinOut[6], 1'h1);
        chk(portcPinOe[6], 1'h0);
        {cExtEn, cExtVal} <= 16'h8080;
        wt(4);
        chk({timer3CaptureInput, portcPinValue[7]}, 2'h3);
        chk(portcPullup, 8'h40);
    endtask
    task t_portd_timers;
        @(posedge clk);
        {portdDirection, timer4CmpDEnable, timer4CmpDOut} <= {8'hC0, 2'h3};
        wt(1);
        chk({portdPinOut[7:6], portdPinOe[7:6]}, 4'hB);
        {portdDirection, dExtEn, dExtVal} <= {8'h00, 8'hC0, 8'h80};
        wt(4);
        chk(portdPinOe[7:6], 2'h0);
        chk({timer0ExtClockIn, timer1ExtClockIn}, 2'h2);
        dExtVal <= 8'h40;
        wt(4);
        chk({timer0ExtClockIn, timer1ExtClockIn}, 2'h1);
        timer4CmpDEnable <= 1'h0;
    endtask
    task t_usart;
        @(posedge clk);
        {usartSyncMode, usartSyncClockOut, portdDirection, dExtEn} <= {2'h3, 8'h20, 8'h00};
        wt(1);
        chk({portdPinOe[5], portdPinOut[5]}, 2'h3);
        {portdDirection, dExtEn, dExtVal} <= {8'h00, 8'h30, 8'h20};
        wt(4);
        chk({usartSyncClockIn, usartClearToSend, timer1CaptureInput}, 3'h6);
        dExtVal <= 8'h10;
        wt(4);
        chk({usartSyncClockIn, usartClearToSend, timer1CaptureInput}, 3'h1);
        {dExtEn, dExtVal, portdDirection, portdOutputLatch} <= {8'h04, 8'h04, 8'h04, 8'h0C};
        {usartTransmitterEnable, usartTransmitData, usartReceiverEnable} <= 3'h5;
        wt(4);
        chk({portdPinOe[3:2], portdPinOut[3]}, 3'h4);
        chk(portdPullup[3:2], 2'h1);
        chk(usartReceiveData, 1'h1);
        {globalPullupDisable, usartTransmitData} <= 2'h3;
        wt(1);
        chk({portdPullup[2], portdPinOut[3]}, 2'h1);
        {usartSyncMode, usartTransmitterEnable, usartReceiverEnable} <= 3'h0;
        {globalPullupDisable, dExtEn, portdDirection} <= {1'h0, 16'h0000};
    endtask
    task t_twowire;
        @(posedge clk);
        {portdOutputLatch, twoWireEnable, sdaOut, sclOut} <= {8'h03, 3'h6};
        {timer0CmpBEnable, timer0CmpBOut} <= 2'h3;
        wt(10);
        chk({portdPinOe[1:0], portdPinOut[1:0]}, 4'h4);
        chk({portdSlewLimit[1:0], portdPullup[1:0]}, 4'hF);
        chk({sdaIn, sclIn}, 2'h2);
        {sclOut, dExtEn, dExtVal} <= {1'h1, 8'h02, 8'h00};
        @(posedge clk);
        dExtEn <= 8'h00;
        repeat (10) begin
            wt(1);
            chk(sdaIn, 1'h1);
        end
        chk({sdaIn, sclIn}, 2'h3);
        dExtEn <= 8'h02;
        wt(10);
        chk(sdaIn, 1'h0);
        {dExtEn, twoWireEnable, portdDirection, portdOutputLatch} <= {9'h000, 16'h0100};
        wt(1);
        chk({portdPinOe[0], portdPinOut[0], portdSlewLimit[1:0]}, 4'hC);
        {timer0CmpBEnable, portdDirection} <= 9'h000;
    endtask
    task t_irq;
        @(posedge clk);
        {sleepInputGate, extIrqEnableLow, extIrqSixEnable} <= 6'h3F;
        {dExtEn, dExtVal, eExtEn, eExtVal, porteDirection} <= {8'h0F, 8'h05, 24'h404000};
        porteOutputLatch <= 8'h40;
        wt(4);
        chk({extIrqLowInput, portdPinValue[3:0]}, 8'h55);
        chk({extIrqSixInput, comparatorPinInput, portePinValue[6]}, 3'h7);
        chk(portePullup, 8'h40);
        chk(portePinOut, 8'h40);
        chk(portePinOe, 8'h00);
        {dExtVal, eExtVal} <= 16'h0A00;
        wt(4);
        chk({extIrqLowInput, portdPinValue[3:0]}, 8'hAA);
        chk({extIrqSixInput, comparatorPinInput, portePinValue[6]}, 3'h0);
        extIrqEnableLow <= 4'h0;
        wt(4);
        chk(portdPinValue[3:0], 4'h0);
    endtask
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #80000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        wt(3);
        t_portc();
        t_portd_timers();
        t_usart();
        t_twowire();
        t_irq();
        tally_and_finish();
    end
endmodule
